// [sim/pcd_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Checker on the divider block's ports
module pcd_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire pcd_pkg::pcd_stat_wr_t nvm_status_wr_o,
  input wire pcd_pkg::pcd_ctrl_t nvm_ctrl_o,
  input wire logic divider_loaded_flag_o,
  input wire logic state_machine_clock_en_o
);
  // A write lands at the edge where ack is seen
  wire logic landed = wb_ack_o && wb_we_i && wb_sel_i[0] && ce_i;
  wire logic [13:0] idx = wb_adr_i[15:2];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property ((wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i) |=> wb_ack_o)
    else $error("request not answered");
  a_upper_zero: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_loaded_sticky: assert property (divider_loaded_flag_o |=> divider_loaded_flag_o)
    else $error("loaded flag dropped");
  a_loaded_set: assert property ((landed && idx == pcd_pkg::IDX_DIVIDER) |=> divider_loaded_flag_o)
    else $error("loaded flag not set");
  // The enable is held off until the divider has a value
  a_quiet_unloaded: assert property (!divider_loaded_flag_o |-> !state_machine_clock_en_o)
    else $error("enable before load");
  a_status_fwd: assert property ((landed && idx == pcd_pkg::IDX_STATUS) |=>
    (nvm_status_wr_o.strobe && nvm_status_wr_o.data == $past(wb_dat_i[7:0])))
    else $error("status write not forwarded");
  a_cmd_write: assert property ((landed && idx == pcd_pkg::IDX_COMMAND) |=>
    nvm_ctrl_o.command == $past(wb_dat_i[7:0]))
    else $error("command byte not stored");
  c_div_write: cover property (landed && idx == pcd_pkg::IDX_DIVIDER);
  c_enable: cover property (state_machine_clock_en_o);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : pcd_chk
bind pcd_top pcd_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .nvm_status_wr_o(nvm_status_wr_o), .nvm_ctrl_o(nvm_ctrl_o),
  .divider_loaded_flag_o(divider_loaded_flag_o),
  .state_machine_clock_en_o(state_machine_clock_en_o));
`default_nettype wire

// [sim/pcd_nvm_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Program/erase engine stand-in: measures the enable spacing
module pcd_nvm_model #(
  parameter logic [7:0] OPTIONS = 8'h02,
  parameter logic [7:0] STATUS = 8'h80
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  output logic [7:0] options_o,
  output logic [7:0] status_o,
  output logic [15:0] count_o,
  output logic [15:0] period_o
);
  // Cycles since the previous enable
  logic [15:0] gap_ff;
  assign options_o = OPTIONS;
  assign status_o = STATUS;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_ff <= 16'h0001;
      count_o <= 16'h0000;
      period_o <= 16'h0000;
    end else if (tick_i) begin
      gap_ff <= 16'h0001;
      count_o <= count_o + 16'h0001;
      period_o <= gap_ff;
    end else begin
      gap_ff <= gap_ff + 16'h0001;
    end
  end
endmodule : pcd_nvm_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the program clock divider
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, loaded, tick;
  logic [7:0] opt, stat, rd;
  logic [15:0] cnt, per;
  logic [15:0] frz;
  pcd_pkg::pcd_stat_wr_t stat_wr;
  pcd_pkg::pcd_ctrl_t ctrl;
  int n_fail = 0;
  int n_compared = 0;
  // Divider settings and the enable period each one gives
  localparam logic [7:0] DIVS [4] = '{8'h02, 8'h41, 8'h3f, 8'h7f};
  localparam int PERS [4] = '{3, 16, 64, 512};
  pcd_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .nvm_options_i(opt), .nvm_status_i(stat), .nvm_status_wr_o(stat_wr),
    .nvm_ctrl_o(ctrl), .divider_loaded_flag_o(loaded), .state_machine_clock_en_o(tick));
  pcd_nvm_model sm (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .options_o(opt),
    .status_o(stat), .count_o(cnt), .period_o(per));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; waits for ack, then one idle cycle
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // Reset seen high at exactly four rising edges
  task automatic restart();
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : restart
  task automatic give_verdict();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    restart();
    bus(1'b0, 16'h6080, 8'h00);
    chk({8'h00, rd}, 16'h0000);
    chk({15'h0000, loaded}, 16'h0000);
    repeat (50) @(posedge clk_i);
    chk(cnt, 16'h0000);
    bus(1'b0, 16'h6084, 8'h00);
    chk({8'h00, rd}, 16'h0002);
    bus(1'b0, 16'h6094, 8'h00);
    chk({8'h00, rd}, 16'h0080);
    bus(1'b0, 16'h6088, 8'h00);
    chk({8'h00, rd}, 16'h0000);
    bus(1'b0, 16'h60a0, 8'h00);
    chk({8'h00, rd}, 16'h0000);
    bus(1'b1, 16'h608c, 8'h5a);
    chk({8'h00, ctrl.configuration}, 16'h005a);
    bus(1'b1, 16'h6094, 8'h30);
    chk({8'h00, stat_wr.data}, 16'h0030);
    bus(1'b1, 16'h6098, 8'h20);
    bus(1'b0, 16'h6098, 8'h00);
    chk({8'h00, rd}, 16'h0020);
    bus(1'b1, 16'h6090, 8'ha5);
    chk({8'h00, ctrl.protection}, 16'h00a5);
    bus(1'b0, 16'h6090, 8'h00);
    chk({8'h00, rd}, 16'h00a5);
    // Each setting needs a fresh reset, as the divider takes one write
    for (int i = 0; i < 4; i++) begin
      restart();
      bus(1'b1, 16'h6080, DIVS[i]);
      chk({15'h0000, loaded}, 16'h0001);
      bus(1'b1, 16'h6080, 8'h45);
      bus(1'b0, 16'h6080, 8'h00);
      chk({8'h00, rd}, {8'h00, 1'b1, DIVS[i][6:0]});
      repeat (3 * PERS[i]) @(posedge clk_i);
      chk(per, PERS[i][15:0]);
    end
    // Clock enable dropped just after a pulse, so the frozen output is low
    do @(posedge clk_i); while (tick !== 1'b1);
    ce_i <= 1'b0;
    @(posedge clk_i);
    frz = cnt;
    repeat (600) @(posedge clk_i);
    chk(cnt, frz);
    ce_i <= 1'b1;
    // The gap spanning the freeze is long; the next one is a full period
    repeat (1536) @(posedge clk_i);
    chk(per, 16'h0200);
    give_verdict();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// [src/pcd_divider.sv]
`timescale 1ns/1ps
`default_nettype none

// Prescaler plus modulus down-counter producing timing enables
module pcd_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic prescale_i,
  input wire logic [5:0] div_i,
  output logic tick_o
);

  // Three-bit prescale counter, runs only while loaded with prescale set
  logic [2:0] pre_ff;
  logic [2:0] nxt_pre;
  // Modulus down-counter
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  // Registered output enable pulse
  logic tick_ff;
  logic nxt_tick;

  // Modulus stage advances every cycle or on prescale wrap
  wire logic pre_wrap = (pre_ff == pcd_pkg::PRESCALE_LAST);
  wire logic step = run_i & (~prescale_i | pre_wrap);
  wire logic at_zero = (cnt_ff == 6'h00);

  // R6: divide by eight
  assign nxt_pre = (run_i & prescale_i) ? pre_ff + 3'h1 : pcd_pkg::RST_PRESCALE_CNT;
  // R4: modulus reload on zero
  assign nxt_cnt = !step ? cnt_ff : (at_zero ? div_i : cnt_ff - 6'h01);
  // R11: one-cycle enable pulse
  assign nxt_tick = step & at_zero;

  // Counter state, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_ff <= pcd_pkg::RST_PRESCALE_CNT;
      cnt_ff <= pcd_pkg::RST_DIV;
      tick_ff <= 1'b0;
    end else if (ce_i) begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule : pcd_divider

`default_nettype wire

// [src/pcd_pkg.sv]
package pcd_pkg;

  // Bus clock rate and period
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Allowed band of the state machine timing clock
  localparam int unsigned SM_CLK_MIN_HZ = 150000;
  localparam int unsigned SM_CLK_MAX_HZ = 200000;

  // Modulus stage limit and prescale ratio
  localparam int unsigned DIV_RATIO_MAX = 64;
  localparam int unsigned PRESCALE_RATIO = 8;

  // Highest bus clock the modulus stage serves alone
  localparam int unsigned DIRECT_MAX_BUS_HZ = SM_CLK_MAX_HZ * DIV_RATIO_MAX;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_DIVIDER = 14'h1820;
  localparam logic [13:0] IDX_OPTIONS = 14'h1821;
  localparam logic [13:0] IDX_RESERVED = 14'h1822;
  localparam logic [13:0] IDX_CONFIG = 14'h1823;
  localparam logic [13:0] IDX_PROTECT = 14'h1824;
  localparam logic [13:0] IDX_STATUS = 14'h1825;
  localparam logic [13:0] IDX_COMMAND = 14'h1826;
  localparam int unsigned NUM_REGS = 7;

  // Divider register field positions
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned PRESCALE_BIT = 6;
  localparam int unsigned LOADED_BIT = 7;

  // Reset values, and the last prescale count before wrap
  localparam logic [5:0] RST_DIV = 6'h00;
  localparam logic [2:0] RST_PRESCALE_CNT = 3'h0;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_PROTECT = 8'h00;
  localparam logic [7:0] RST_COMMAND = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // Control registers handed to the program/erase state machine
  typedef struct packed {
    logic [7:0] configuration;
    logic [7:0] protection;
    logic [7:0] command;
  } pcd_ctrl_t;

  // Write event toward the status register owner
  typedef struct packed {
    logic strobe;
    logic [7:0] data;
  } pcd_stat_wr_t;

  // Bus handshake states
  typedef enum logic [0:0] {
    PCD_BUS_IDLE = 1'b0,
    PCD_BUS_ACK = 1'b1
  } pcd_bus_state_t;

endpackage : pcd_pkg

// [src/pcd_top.sv]
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Seven byte registers at consecutive bus addresses.
// R2: Software loads divider before any operation.
// R3: Bus clock divided toward 150-200 kHz.
// R4: Six-bit field divides by value plus one.
// R5: Above 12.8 MHz, prescaler must be used.
// R6: Prescale bit inserts divide-by-eight stage.
// R7: Software computes divider, sets bit six.
// R8: Top bit read-only, shows divider written.
// R9: Any divider write sets loaded flag.
// R10: Only first divider write after reset counts.
// R11: Zero count pulses enable, reloads counter.
module pcd_top (
  // Bus clock and synchronous reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Freezes all state while low
  input wire logic ce_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Option byte from the nonvolatile option store
  input wire logic [7:0] nvm_options_i,
  // Status byte kept by the program/erase state machine
  input wire logic [7:0] nvm_status_i,
  // Status write event toward the state machine
  output var pcd_pkg::pcd_stat_wr_t nvm_status_wr_o,
  // Configuration, protection and command bytes
  output var pcd_pkg::pcd_ctrl_t nvm_ctrl_o,
  // Divider loaded indication
  output logic divider_loaded_flag_o,
  // One-cycle timing enable for the state machine
  output logic state_machine_clock_en_o
);

  // Decode of a word address against a register index
  function automatic logic reg_hit(
    input logic [15:0] adr,
    input logic [13:0] idx
  );
    reg_hit = (adr[15:2] == idx);
  endfunction : reg_hit

  // Register index table, in read-mux order
  localparam logic [13:0] IDX_TABLE [pcd_pkg::NUM_REGS] = '{
    pcd_pkg::IDX_DIVIDER,
    pcd_pkg::IDX_OPTIONS,
    pcd_pkg::IDX_RESERVED,
    pcd_pkg::IDX_CONFIG,
    pcd_pkg::IDX_PROTECT,
    pcd_pkg::IDX_STATUS,
    pcd_pkg::IDX_COMMAND
  };

  // Handshake state
  pcd_pkg::pcd_bus_state_t bus_ff;
  pcd_pkg::pcd_bus_state_t nxt_bus;

  // Divider field, prescale enable and loaded flag
  logic [5:0] div_ff;
  logic prescale_by_eight_enable_ff;
  logic divider_loaded_flag_ff;

  // Plain read/write control bytes
  logic [7:0] cfg_ff;
  logic [7:0] prot_ff;
  logic [7:0] cmd_ff;

  // Registered read data and status write event
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  pcd_pkg::pcd_stat_wr_t stat_wr_ff;
  pcd_pkg::pcd_stat_wr_t nxt_stat_wr;

  // A request is seen while idle; it completes in the ack state
  wire logic req = wb_cyc_i & wb_stb_i;
  wire logic accept = req & (bus_ff == pcd_pkg::PCD_BUS_IDLE);
  wire logic finish = req & (bus_ff == pcd_pkg::PCD_BUS_ACK);

  // Writes land only on the low byte lane, at the completing edge
  wire logic wr_lane = finish & wb_we_i & wb_sel_i[0];
  wire logic [7:0] wbyte = wb_dat_i[7:0];

  // One-hot hit vector over the register table
  logic [pcd_pkg::NUM_REGS-1:0] hit;
  // Current byte value of each register as read
  logic [7:0] reg_val [pcd_pkg::NUM_REGS];
  // Per-register read terms, zero when not selected
  logic [7:0] rd_term [pcd_pkg::NUM_REGS];

  // R1: consecutive register decode
  genvar gi;
  generate
    for (gi = 0; gi < pcd_pkg::NUM_REGS; gi++) begin : g_dec
      assign hit[gi] = reg_hit(wb_adr_i, IDX_TABLE[gi]);
      assign rd_term[gi] = hit[gi] ? reg_val[gi] : 8'h00;
    end
  endgenerate

  // Named strobes for the writable registers
  wire logic wr_div = wr_lane & reg_hit(wb_adr_i, pcd_pkg::IDX_DIVIDER);
  wire logic wr_cfg = wr_lane & hit[3];
  wire logic wr_prot = wr_lane & hit[4];
  wire logic wr_stat = wr_lane & hit[5];
  wire logic wr_cmd = wr_lane & hit[6];

  // R8: loaded flag sits in the top bit, read-only
  assign reg_val[0] = {divider_loaded_flag_ff, prescale_by_eight_enable_ff, div_ff};
  // Options come straight from the option store
  assign reg_val[1] = nvm_options_i;
  // Reserved slot always reads zero
  assign reg_val[2] = 8'h00;
  assign reg_val[3] = cfg_ff;
  assign reg_val[4] = prot_ff;
  // Status is owned by the state machine side
  assign reg_val[5] = nvm_status_i;
  assign reg_val[6] = cmd_ff;

  // Read mux: OR of the selected term, zero for unmapped addresses
  always_comb begin
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < pcd_pkg::NUM_REGS; i++) begin
      acc = acc | rd_term[i];
    end
    nxt_rdata = {24'h000000, acc};
  end

  // Handshake: ack one cycle after the request, then idle again
  always_comb begin
    case (bus_ff)
      pcd_pkg::PCD_BUS_IDLE: begin
        nxt_bus = accept ? pcd_pkg::PCD_BUS_ACK : pcd_pkg::PCD_BUS_IDLE;
      end
      pcd_pkg::PCD_BUS_ACK: begin
        nxt_bus = pcd_pkg::PCD_BUS_IDLE;
      end
      default: begin
        nxt_bus = pcd_pkg::PCD_BUS_IDLE;
      end
    endcase
  end

  // Bus state and read data capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_ff <= pcd_pkg::PCD_BUS_IDLE;
      rdata_ff <= pcd_pkg::RST_RDATA;
    end else if (ce_i) begin
      bus_ff <= nxt_bus;
      // Data is sampled while idle so it is stable during ack
      if (accept) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Ack is the handshake state gated by the request; it drops the cycle after
  assign wb_ack_o = (bus_ff == pcd_pkg::PCD_BUS_ACK) & req;
  assign wb_dat_o = rdata_ff;

  // Divider register: first write after reset wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= pcd_pkg::RST_DIV;
      prescale_by_eight_enable_ff <= 1'b0;
    // R10: later writes ignored
    end else if (ce_i && wr_div && !divider_loaded_flag_ff) begin
      div_ff <= wbyte[pcd_pkg::DIV_LSB +: pcd_pkg::DIV_W];
      // R5: fast bus prescaler
      // R6: prescale enable latched
      prescale_by_eight_enable_ff <= wbyte[pcd_pkg::PRESCALE_BIT];
    end
  end

  // Loaded flag: set by any accepted divider write, cleared by reset only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divider_loaded_flag_ff <= 1'b0;
    // R9: set regardless of value
    end else if (ce_i && wr_div) begin
      divider_loaded_flag_ff <= 1'b1;
    end
  end

  // Ordinary control bytes, stored as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= pcd_pkg::RST_CONFIG;
      prot_ff <= pcd_pkg::RST_PROTECT;
      cmd_ff <= pcd_pkg::RST_COMMAND;
    end else if (ce_i) begin
      if (wr_cfg) begin
        cfg_ff <= wbyte;
      end
      if (wr_prot) begin
        prot_ff <= wbyte;
      end
      if (wr_cmd) begin
        cmd_ff <= wbyte;
      end
    end
  end

  // Status writes are passed on as a one-cycle event; the flags
  // themselves live with the state machine, which applies them
  // One assignment for the whole struct keeps a single driver
  assign nxt_stat_wr = {wr_stat, (wr_stat ? wbyte : stat_wr_ff.data)};

  // Status write event register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_wr_ff <= '0;
    end else if (ce_i) begin
      stat_wr_ff <= nxt_stat_wr;
    end
  end

  assign nvm_status_wr_o = stat_wr_ff;
  // Field order follows the struct: configuration, protection, command
  assign nvm_ctrl_o = {cfg_ff, prot_ff, cmd_ff};
  assign divider_loaded_flag_o = divider_loaded_flag_ff;

  // R2: chain idles until loaded
  // R3: chain clocked by bus clock
  // The chain sees the bus clock only; picking a legal ratio for the
  // actual bus rate is left to software, the hardware never checks it
  pcd_divider u_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(divider_loaded_flag_ff),
    .prescale_i(prescale_by_eight_enable_ff),
    .div_i(div_ff),
    .tick_o(state_machine_clock_en_o)
  );

endmodule : pcd_top

`default_nettype wire
